// >>> rtl/pdp_port.v
// mii / rmii data port with transmit fifo
`include "pdp_consts.vh"

// ----------------------------------------------------------------
// synchronous fifo
// ----------------------------------------------------------------
module pdp_fifo #(
  parameter WIDTH = `PDP_NIB_W,
  parameter DEPTH = `PDP_FIFO_DEPTH,
  parameter AW    = `PDP_FIFO_AW
) (
  input  wire             clk,
  input  wire             rstn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------------------------------
// data port top
// ----------------------------------------------------------------
// Overview of operation
// R1: mii transmit clock runs continuously, 2.5mhz at 10mbps, 25mhz at 100mbps.
// R2: mac frames transmit enable from first preamble nibble to last nibble.
// R3: mac changes enable and data only on the transmit clock.
// R4: nibbles taken while enable high; data ignored while enable low.
// R5: at 10mbps receive clock recovered with carrier, else from reference.
// R6: at 100mbps receive clock recovered, from reference only when link down.
// R7: receive clock 2.5mhz or 25mhz, times valid, data and error.
// R8: at 10mbps receive valid rises on start-of-frame delimiter, holds to end.
// R9: at 100mbps receive valid high from first preamble to last nibble.
// R10: one nibble per receive clock while valid, all on that clock.
// R11: symbol error raises receive error for at least one receive period.
// R12: mac ignores receive error while receive valid is low.
// R13: at 10mbps carrier sense rises on preamble, falls on end-of-frame.
// R14: at 100mbps carrier rises on j/k, falls on t/r or bare idle.
// R15: half duplex collision when transmit and receive both active.
// R16: straps 000 with 25mhz source select mii mode.
// R17: external-reference variant with straps 001 selects rmii.
// R18: crystal variant with straps 001 selects rmii and drives reference out.
// R19: mii uses separate nibble-wide transmit and receive groups.
// R20: rmii uses di-bit transmit and receive paths on one reference.
// R21: in rmii the upper two transmit data bits are tied low.
// R22: rmii carrier/valid asserts asynchronously; data idle until decoded.
// R23: in rmii the mac rebuilds collision from enable and carrier/valid.
// R24: clock rates and collision follow the resolved speed and duplex.
module pdp_port (
  input  wire                      clk,
  input  wire                      rstn,
  input  wire [`PDP_STRAP_W-1:0]   cfg_strap,
  input  wire                      xtal_variant,
  input  wire                      link_up,
  input  wire                      speed100,
  input  wire                      full_duplex,
  input  wire                      line_rec_clk,
  input  wire                      line_carrier,
  input  wire                      line_rx_frame,
  input  wire                      line_rx_sfd,
  input  wire                      line_rx_pre,
  input  wire                      line_rx_eof,
  input  wire                      line_jk,
  input  wire                      line_tr,
  input  wire                      line_idle,
  input  wire                      line_rx_err,
  input  wire [`PDP_NIB_W-1:0]     line_rx_nib,
  output wire                      line_tx_active,
  output wire                      line_tx_valid,
  input  wire                      line_tx_ready,
  output wire [`PDP_NIB_W-1:0]     line_tx_nib,
  input  wire                      mac_tx_en,
  input  wire [`PDP_NIB_W-1:0]     mac_txd,
  output wire                      tx_clk_o,
  output wire                      rx_clk_o,
  output wire                      ref_clk_o,
  output wire                      rmii_mode,
  output wire                      tx_fifo_ready,
  output reg                       tx_overrun_q,
  output reg                       rx_dv_q,
  output reg  [`PDP_NIB_W-1:0]     rxd_q,
  output reg                       rx_er_q,
  output reg                       crs_q,
  output wire                      col,
  output wire                      crs_dv,
  output reg  [`PDP_DIBIT_W-1:0]   rmii_rxd_q
);
  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  reg [`PDP_STRAP_W-1:0] strap_s1_q;
  reg [`PDP_STRAP_W-1:0] strap_s2_q;
  reg                    capt_done_q;
  reg                    rmii_q;
  reg                    xtal_s1_q;
  reg                    xtal_s2_q;
  reg                    xtal_q;

  always @(posedge clk) begin
    strap_s1_q <= cfg_strap;
    strap_s2_q <= strap_s1_q;
    xtal_s1_q  <= xtal_variant;
    xtal_s2_q  <= xtal_s1_q;
  end

  always @(posedge clk) begin
    if (!rstn) begin
      capt_done_q <= 1'b0;
      rmii_q      <= 1'b0;
      xtal_q      <= 1'b0;
    end else if (!capt_done_q) begin
      capt_done_q <= 1'b1;
      rmii_q      <= (strap_s2_q == `PDP_STRAP_RMII); // R16 R17 R18
      xtal_q      <= xtal_s2_q;
    end
  end

  assign rmii_mode = rmii_q;
  // crystal variant drives the reference out in rmii
  assign ref_clk_o = (rmii_q & xtal_q) ? clk : 1'b0; // R18

  // ----------------------------------------------------------------
  // link mode tracking and period timing
  // ----------------------------------------------------------------
  reg                  spd_q;
  reg                  dup_q;
  reg                  link_q;
  reg [`PDP_CNT_W-1:0] cnt_q;
  reg [`PDP_CNT_W-1:0] cnt_d;
  reg                  div_q;
  wire                 tick;
  localparam integer   LAST10 = `PDP_PER10_CYC - 1;
  localparam integer   MID10  = `PDP_HALF10_CYC - 1;

  always @(posedge clk) begin
    if (!rstn) begin
      spd_q  <= 1'b0;
      dup_q  <= 1'b0;
      link_q <= 1'b0;
    end else begin
      spd_q  <= speed100; // R24
      dup_q  <= full_duplex; // R24
      link_q <= link_up;
    end
  end

  assign tick = spd_q |
                (cnt_q == LAST10[`PDP_CNT_W-1:0]); // R7

  always @* begin
    cnt_d = cnt_q + 1'b1;
    if (tick) begin
      cnt_d = {`PDP_CNT_W{1'b0}};
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= {`PDP_CNT_W{1'b0}};
      div_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (spd_q) begin
        div_q <= 1'b0;
      end else if (cnt_q == MID10[`PDP_CNT_W-1:0]) begin
        div_q <= 1'b1;
      end else if (tick) begin
        div_q <= 1'b0;
      end
    end
  end

  // reference-derived clock: clk at 100, divided by ten at 10
  wire ref_derived;
  assign ref_derived = spd_q ? clk : div_q;
  assign tx_clk_o    = ref_derived; // R1

  // receive clock source selection
  wire use_rec;
  assign use_rec  = link_q & (spd_q | line_carrier); // R5 R6
  assign rx_clk_o = use_rec ? line_rec_clk : ref_derived; // R5 R6

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  reg                   half_q;
  reg [`PDP_DIBIT_W-1:0] low_q;
  reg                   push;
  reg [`PDP_NIB_W-1:0]  push_nib;
  wire                  fifo_in_ready;
  wire [`PDP_DIBIT_W-1:0] tx_dibit;

  assign tx_dibit = mac_txd[`PDP_DIBIT_W-1:0]; // R21

  always @* begin
    push     = 1'b0;
    push_nib = `PDP_IDLE_NIB;
    if (tick & mac_tx_en) begin // R2 R3 R4
      if (!rmii_q) begin
        push     = 1'b1; // R19
        push_nib = mac_txd;
      end else if (half_q) begin
        push     = 1'b1; // R20
        push_nib = {tx_dibit, low_q};
      end
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      half_q       <= 1'b0;
      low_q        <= `PDP_IDLE_DIBIT;
      tx_overrun_q <= 1'b0;
    end else begin
      if (!mac_tx_en) begin
        half_q <= 1'b0; // R4
      end else if (tick & rmii_q) begin
        half_q <= ~half_q;
        low_q  <= tx_dibit;
      end
      if (push & ~fifo_in_ready) begin
        tx_overrun_q <= 1'b1;
      end else if (!mac_tx_en) begin
        tx_overrun_q <= 1'b0;
      end
    end
  end

  assign tx_fifo_ready  = fifo_in_ready;
  assign line_tx_active = mac_tx_en;

  pdp_fifo #(
    .WIDTH (`PDP_NIB_W),
    .DEPTH (`PDP_FIFO_DEPTH),
    .AW    (`PDP_FIFO_AW)
  ) u_tx_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_nib),
    .out_valid (line_tx_valid),
    .out_ready (line_tx_ready),
    .out_data  (line_tx_nib)
  );

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  reg  rx_dv_d;
  reg  crs_d;
  reg  err_pend_q;
  reg  rhalf_q;
  wire frame_on;

  assign frame_on = link_q & line_rx_frame;

  always @* begin
    if (spd_q) begin
      rx_dv_d = frame_on; // R9
    end else begin
      rx_dv_d = frame_on & (line_rx_sfd | rx_dv_q); // R8
    end
  end

  always @* begin
    crs_d = crs_q;
    if (!link_q) begin
      crs_d = 1'b0;
    end else if (spd_q) begin
      if (line_tr | (line_idle & crs_q)) begin
        crs_d = 1'b0; // R14
      end else if (line_jk) begin
        crs_d = 1'b1; // R14
      end
    end else begin
      if (line_rx_eof) begin
        crs_d = 1'b0; // R13
      end else if (line_rx_pre) begin
        crs_d = 1'b1; // R13
      end
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      rx_dv_q    <= 1'b0;
      rxd_q      <= `PDP_IDLE_NIB;
      rx_er_q    <= 1'b0;
      crs_q      <= 1'b0;
      err_pend_q <= 1'b0;
      rhalf_q    <= 1'b0;
      rmii_rxd_q <= `PDP_IDLE_DIBIT;
    end else begin
      crs_q <= crs_d;
      // an error seen between ticks is held until the next period
      if (line_rx_err & frame_on) begin
        err_pend_q <= 1'b1;
      end else if (tick) begin
        err_pend_q <= 1'b0;
      end
      if (tick) begin
        rx_dv_q <= rx_dv_d; // R10
        rxd_q   <= rx_dv_d ? line_rx_nib : `PDP_IDLE_NIB; // R10
        rx_er_q <= rx_dv_d & (line_rx_err | err_pend_q); // R11
        if (rmii_q & rx_dv_d) begin
          rhalf_q    <= ~rhalf_q; // R20
          rmii_rxd_q <= rhalf_q ? line_rx_nib[3:2]
                                : line_rx_nib[1:0];
        end else begin
          rhalf_q    <= 1'b0;
          rmii_rxd_q <= `PDP_IDLE_DIBIT; // R22
        end
      end
    end
  end

  // asynchronous carrier term for rmii
  assign crs_dv = rmii_q & link_q &
                  (line_carrier | rx_dv_q); // R22

  // collision only in mii half duplex; rmii mac rebuilds it
  assign col = ~rmii_q & ~dup_q & mac_tx_en & crs_q; // R15 R23 R24
endmodule

// >>> rtl/pdp_consts.vh
// constants for the phy mac-facing data port
`ifndef PDP_CONSTS_VH
`define PDP_CONSTS_VH

// interface-select strap codes
`define PDP_STRAP_W        3
`define PDP_STRAP_MII      3'h0
`define PDP_STRAP_RMII     3'h1

// clock rates in hz
`define PDP_CLK_HZ         25000000
`define PDP_RATE10_HZ      2500000
`define PDP_RATE100_HZ     25000000

// cycles of clk per nibble or di-bit period at each speed
`define PDP_PER10_CYC      (`PDP_CLK_HZ / `PDP_RATE10_HZ)
`define PDP_PER100_CYC     (`PDP_CLK_HZ / `PDP_RATE100_HZ)
`define PDP_HALF10_CYC     (`PDP_PER10_CYC / 2)

// period counter width
`define PDP_CNT_W          4

// data widths
`define PDP_NIB_W          4
`define PDP_DIBIT_W        2

// transmit fifo shape
`define PDP_FIFO_DEPTH     8
`define PDP_FIFO_AW        3

// idle values
`define PDP_IDLE_NIB       4'h0
`define PDP_IDLE_DIBIT     2'h0

`endif

// >>> test/pdp_port_assertions.sv
// concurrent checks on the data port outputs
module pdp_port_chk (
  input wire       clk,
  input wire       rstn,
  input wire       speed100,
  input wire       link_up,
  input wire       line_rx_frame,
  input wire [3:0] line_rx_nib,
  input wire       mac_tx_en,
  input wire       line_tx_active,
  input wire       ref_clk_o,
  input wire       rmii_mode,
  input wire       tx_overrun_q,
  input wire       rx_dv_q,
  input wire [3:0] rxd_q,
  input wire       rx_er_q,
  input wire       crs_q,
  input wire       col,
  input wire       crs_dv
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  col_gating_a: assert property (col |-> mac_tx_en && crs_q && !rmii_mode)
    else $error("collision without transmit and carrier");
  rxd_idle_a: assert property (!rx_dv_q |-> rxd_q == 4'h0)
    else $error("receive data not idle");
  rxer_valid_a: assert property (rx_er_q |-> rx_dv_q)
    else $error("receive error outside valid");
  ref_off_a: assert property (!rmii_mode |-> !ref_clk_o)
    else $error("reference clock out in mii mode");
  crsdv_mode_a: assert property (crs_dv |-> rmii_mode)
    else $error("carrier valid in mii mode");
  tx_active_a: assert property (line_tx_active == mac_tx_en)
    else $error("transmit activity differs from enable");
  overrun_clr_a: assert property (!mac_tx_en |=> !tx_overrun_q)
    else $error("overrun kept with enable low");
  crs_link_a: assert property (!link_up |=> ##1 !crs_q)
    else $error("carrier kept with link down");
  rx_fast_a: assert property ($past(rstn) && $past(speed100) &&
    $past(link_up) && line_rx_frame && !rmii_mode
    |=> rx_dv_q && rxd_q == $past(line_rx_nib))
    else $error("100m receive nibble not delivered");
endmodule

bind pdp_port pdp_port_chk u_chk (.clk, .rstn, .speed100, .link_up,
  .line_rx_frame, .line_rx_nib, .mac_tx_en, .line_tx_active, .ref_clk_o,
  .rmii_mode, .tx_overrun_q, .rx_dv_q, .rxd_q, .rx_er_q, .crs_q, .col,
  .crs_dv);

// >>> test/pdp_mac_model.sv
// mac transmit side model: ten-symbol frames counting up from base
module pdp_mac_model (
  input  wire       clk,
  input  wire       rstn,
  input  wire       go,
  input  wire       rmii,
  input  wire [3:0] base,
  output reg        mac_tx_en = 1'b0,
  output reg  [3:0] mac_txd = 4'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  always @(posedge clk) begin
    if (!rstn || (go && n == 0))
      n <= rstn ? 10 : 0;
    else if (n > 0)
      n <= n - 1;
    mac_tx_en <= (n > 0);
    if (n == 0)
      mac_txd <= 4'h0;
    else if (rmii)
      mac_txd <= {2'b00, 2'(base + 4'(10 - n))};
    else
      mac_txd <= base + 4'(10 - n);
  end
endmodule

// >>> test/testbench.sv
// self-checking bench for the mii / rmii data port
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rstn = 1'b0, xtal_variant = 1'b0, go = 1'b0;
  logic        link_up = 1'b1, speed100 = 1'b1, full_duplex = 1'b1;
  logic        line_rec_clk = 1'b0, line_carrier = 1'b0;
  logic        line_rx_frame = 1'b0, line_rx_sfd = 1'b0, line_rx_pre = 1'b0;
  logic        line_rx_eof = 1'b0, line_jk = 1'b0, line_tr = 1'b0;
  logic        line_idle = 1'b0, line_rx_err = 1'b0, line_tx_ready = 1'b0;
  logic [2:0]  cfg_strap = 3'h0;
  logic [3:0]  line_rx_nib = 4'h0, base = 4'h0, prev;
  logic [31:0] seed = 32'ha20a1c1c, k, m;
  wire         mac_tx_en, line_tx_active, line_tx_valid, tx_clk_o, col;
  wire         rx_clk_o, ref_clk_o, rmii_mode, tx_fifo_ready, tx_overrun_q;
  wire         rx_dv_q, rx_er_q, crs_q, crs_dv;
  wire  [3:0]  mac_txd, line_tx_nib, rxd_q;
  wire  [1:0]  rmii_rxd_q;
  int          err_count = 0, compares = 0, i;
  pdp_port dut (.clk, .rstn, .cfg_strap, .xtal_variant, .link_up, .speed100,
    .full_duplex, .line_rec_clk, .line_carrier, .line_rx_frame, .line_rx_sfd,
    .line_rx_pre, .line_rx_eof, .line_jk, .line_tr, .line_idle, .line_rx_err,
    .line_rx_nib, .line_tx_active, .line_tx_valid, .line_tx_ready,
    .line_tx_nib, .mac_tx_en, .mac_txd, .tx_clk_o, .rx_clk_o, .ref_clk_o,
    .rmii_mode, .tx_fifo_ready, .tx_overrun_q, .rx_dv_q, .rxd_q, .rx_er_q,
    .crs_q, .col, .crs_dv, .rmii_rxd_q);
  pdp_mac_model mac (.clk, .rstn, .go, .rmii (cfg_strap == 3'h1), .base,
    .mac_tx_en, .mac_txd);
  initial forever #20 clk = ~clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic [3:0] exp_pair(input [3:0] b, input int p);
    return {2'(b + 4'(2 * p + 1)), 2'(b + 4'(2 * p))};
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t seen %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task print_verdict();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task reset(input [2:0] s, input int n);
    rstn <= 1'b0;
    cfg_strap <= s;
    cyc(n);
    rstn <= 1'b1;
    cyc(3);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    reset(3'h0, 2);
    #1 chk(rmii_mode, 1'b0);
    for (i = 0; i < 24; i++) begin
      cyc(1);
      k = xs();
      line_rx_nib <= k[3:0];
      line_rx_frame <= (i < 20);
      line_rx_err <= (i == 9);
      line_jk <= (i == 2);
      line_tr <= (i == 5);
      line_rec_clk <= k[4];
      #1 chk(rx_clk_o, line_rec_clk);
      if (i > 0 && i < 21) begin
        chk(rx_dv_q, 1'b1);
        chk(rxd_q, prev);
      end
      if (i > 20)
        chk(rx_dv_q, 1'b0);
      if (i == 10)
        chk(rx_er_q, 1'b1);
      if (i == 3)
        chk(crs_q, 1'b1);
      if (i == 6)
        chk(crs_q, 1'b0);
      prev = k[3:0];
    end
    cyc(1);
    line_jk <= 1'b1;
    full_duplex <= 1'b0;
    base <= k[7:4];
    go <= 1'b1;
    cyc(1);
    line_jk <= 1'b0;
    go <= 1'b0;
    #1 chk(crs_q, 1'b1);
    cyc(9);
    #1 chk(col, 1'b1);
    cyc(1);
    #1 chk(tx_fifo_ready, 1'b0);
    chk(tx_overrun_q, 1'b1);
    cyc(1);
    line_tx_ready <= 1'b1;
    #1 chk(tx_overrun_q, 1'b1);
    for (i = 0; i < 8; i++) begin
      chk(line_tx_valid, 1'b1);
      chk(line_tx_nib, 4'(base + i));
      cyc(1);
      #1;
    end
    chk(line_tx_valid, 1'b0);
    chk(tx_overrun_q, 1'b0);
    cyc(1);
    line_idle <= 1'b1;
    cyc(1);
    line_idle <= 1'b0;
    link_up <= 1'b0;
    line_rec_clk <= 1'b0;
    #1 chk(crs_q, 1'b0);
    cyc(3);
    #1 chk(rx_clk_o, 1'b1);
    cyc(1);
    link_up <= 1'b1;
    speed100 <= 1'b0;
    line_rec_clk <= 1'b1;
    line_rx_frame <= 1'b1;
    cyc(12);
    #1 chk(rx_dv_q, 1'b0);
    chk(rx_clk_o, tx_clk_o);
    k = 0;
    m = 0;
    repeat (10) begin
      cyc(1);
      #1 k = k + tx_clk_o;
      m = m + rx_clk_o;
    end
    chk(k, 5);
    chk(m, 5);
    line_rx_sfd <= 1'b1;
    line_rx_pre <= 1'b1;
    cyc(1);
    line_rx_pre <= 1'b0;
    #1 chk(crs_q, 1'b1);
    cyc(9);
    line_rx_sfd <= 1'b0;
    line_rx_eof <= 1'b1;
    #1 chk(rx_dv_q, 1'b1);
    cyc(1);
    line_rx_eof <= 1'b0;
    line_rx_frame <= 1'b0;
    xtal_variant <= 1'b1;
    #1 chk(crs_q, 1'b0);
    reset(3'h1, 4);
    #1 chk(rmii_mode, 1'b1);
    #10 chk(ref_clk_o, 1'b1);
    cyc(1);
    line_carrier <= 1'b1;
    #1 chk(crs_dv, 1'b1);
    cyc(1);
    speed100 <= 1'b1;
    line_tx_ready <= 1'b0;
    cyc(2);
    k = xs();
    base <= k[11:8];
    line_rx_nib <= k[15:12];
    line_rx_frame <= 1'b1;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    #1 chk(rmii_rxd_q, k[13:12]);
    cyc(1);
    #1 chk(rmii_rxd_q, k[15:14]);
    chk(col, 1'b0);
    cyc(11);
    line_tx_ready <= 1'b1;
    for (i = 0; i < 5; i++) begin
      #1 chk(line_tx_valid, 1'b1);
      chk(line_tx_nib, exp_pair(base, i));
      cyc(1);
    end
    #1 chk(line_tx_valid, 1'b0);
    print_verdict();
  end
endmodule
